// File: design/ldo_ctrl_bank.sv
// control and status register bank for the regulator group
`include "ldo_map.svh"

module ldo_ctrl_bank
  import ldo_pkg::*;
(
  // clock, reset, freeze
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire ldo_word_t reg_wdata,
  input wire logic reg_rd_en,
  output ldo_word_t reg_rdata,
  output logic reg_rd_valid,
  // mode and enable requests from outside the bank
  input wire logic clock_request_input,
  input wire logic [8:0] hw_on_request,
  input wire logic sim_one_sw_enable,
  input wire logic sim_two_sw_enable,
  input wire logic general_supply_one_sw_enable,
  input wire logic general_supply_two_sw_enable,
  input wire logic general_supply_three_sw_enable,
  // analog status
  input wire logic [6:0] overcurrent_flags,
  input wire logic rf_supply_lowpower,
  input wire logic memory_supply_on,
  input wire logic memory_supply_lowpower,
  input wire logic io_supply_on,
  input wire logic io_supply_lowpower,
  // regulator controls
  output logic [8:0] supply_enable,
  output logic [3:0] supply_lowpower,
  output ldo_mv_t [5:0] supply_nominal_mv,
  output ldo_trim_t [5:0] supply_trim_mv
);

  localparam int NUM_RW = 11;

  localparam ldo_word_t RW_MASK [NUM_RW] = '{
    `LDO_MASK_LP_CTRL, `LDO_MASK_FOCUS_TRIM, `LDO_MASK_SIM_TRIM,
    `LDO_MASK_SIM_TRIM, `LDO_MASK_LP_CTRL, `LDO_MASK_VIB_TRIM,
    `LDO_MASK_ON_SOURCE, `LDO_MASK_CAM_CTRL, `LDO_MASK_CAMD_TRIM,
    `LDO_MASK_CAM_CTRL, `LDO_MASK_CAMIO_TRIM
  };

  localparam ldo_word_t RW_RESET [NUM_RW] = '{
    `LDO_RST_ZERO, `LDO_RST_FOCUS_TRIM, `LDO_RST_SIM_TRIM,
    `LDO_RST_SIM_TRIM, `LDO_RST_ZERO, `LDO_RST_VIB_TRIM,
    `LDO_RST_ZERO, `LDO_RST_ZERO, `LDO_RST_CAM_TRIM,
    `LDO_RST_ZERO, `LDO_RST_CAM_TRIM
  };

  // writable register address to storage slot
  function automatic logic [4:0] rw_slot(input logic [15:0] a);
    logic [4:0] s;
    s = 5'h1f;
    if (a == `LDO_OFS_FOCUS_CTRL)
      s = {1'b0, LDO_R_FOCUS_CTRL};
    else if (a == `LDO_OFS_FOCUS_TRIM)
      s = {1'b0, LDO_R_FOCUS_TRIM};
    else if (a == `LDO_OFS_SIM1_TRIM)
      s = {1'b0, LDO_R_SIM1_TRIM};
    else if (a == `LDO_OFS_SIM2_TRIM)
      s = {1'b0, LDO_R_SIM2_TRIM};
    else if (a == `LDO_OFS_VIB_CTRL)
      s = {1'b0, LDO_R_VIB_CTRL};
    else if (a == `LDO_OFS_VIB_TRIM)
      s = {1'b0, LDO_R_VIB_TRIM};
    else if (a == `LDO_OFS_ON_SOURCE)
      s = {1'b0, LDO_R_ON_SOURCE};
    else if (a == `LDO_OFS_CAMD_CTRL)
      s = {1'b0, LDO_R_CAMD_CTRL};
    else if (a == `LDO_OFS_CAMD_TRIM)
      s = {1'b0, LDO_R_CAMD_TRIM};
    else if (a == `LDO_OFS_CAMIO_CTRL)
      s = {1'b0, LDO_R_CAMIO_CTRL};
    else if (a == `LDO_OFS_CAMIO_TRIM)
      s = {1'b0, LDO_R_CAMIO_TRIM};
    return s;
  endfunction

  // trim code to offset in millivolts
  function automatic ldo_trim_t trim_mv(input logic [3:0] code,
                                        input logic at_1v3);
    logic [2:0] steps;
    logic [8:0] mag;
    steps = code[2:0];
    if (at_1v3 && !code[3] && code[2])
      steps = {1'b0, code[1:0]};
    mag = 9'({6'h00, steps} * 9'd20);
    if (code[3])
      return $signed(9'd160 - mag);
    return $signed(9'd0 - mag);
  endfunction

  // three-bit code shared by focus and vibrator supplies
  function automatic ldo_mv_t vcode3_mv(input logic [2:0] code);
    ldo_mv_t v;
    case (code)
      3'h0: v = 12'd1200;
      3'h1: v = 12'd1300;
      3'h2: v = 12'd1500;
      3'h3: v = 12'd1800;
      3'h4: v = 12'd2000;
      3'h5: v = 12'd2800;
      3'h6: v = 12'd3000;
      default: v = 12'd3300;
    endcase
    return v;
  endfunction

  function automatic ldo_mv_t camd_mv(input logic [1:0] code);
    ldo_mv_t v;
    case (code)
      2'h0: v = 12'd1200;
      2'h1: v = 12'd1350;
      2'h2: v = 12'd1500;
      default: v = 12'd1800;
    endcase
    return v;
  endfunction

  ldo_word_t regs_q [NUM_RW];
  ldo_word_t rdata_d;
  ldo_word_t rdata_q;
  logic rd_valid_q;
  logic [8:0] enable_d;
  logic [8:0] enable_q;
  logic [3:0] lowpower_d;
  logic [3:0] lowpower_q;
  ldo_mv_t [5:0] nominal_d;
  ldo_mv_t [5:0] nominal_q;
  ldo_trim_t [5:0] trim_d;
  ldo_trim_t [5:0] trim_q;

  wire [4:0] wr_slot = rw_slot(reg_addr);
  wire [4:0] rd_slot = rw_slot(reg_addr);
  wire wr_hit = reg_wr_en && (wr_slot != 5'h1f);

  // writable storage; read-only bit positions never store
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++)
    begin : g_rw
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
          regs_q[gi] <= RW_RESET[gi] & RW_MASK[gi];
        else if (clk_en && wr_hit && wr_slot == 5'(gi))
          regs_q[gi] <= reg_wdata & RW_MASK[gi];
      end
    end
  endgenerate

  wire ldo_word_t focus_ctrl = regs_q[LDO_R_FOCUS_CTRL];
  wire ldo_word_t focus_trim = regs_q[LDO_R_FOCUS_TRIM];
  wire ldo_word_t sim1_trim = regs_q[LDO_R_SIM1_TRIM];
  wire ldo_word_t sim2_trim = regs_q[LDO_R_SIM2_TRIM];
  wire ldo_word_t vib_ctrl = regs_q[LDO_R_VIB_CTRL];
  wire ldo_word_t vib_trim = regs_q[LDO_R_VIB_TRIM];
  wire ldo_word_t on_source = regs_q[LDO_R_ON_SOURCE];
  wire ldo_word_t camd_ctrl = regs_q[LDO_R_CAMD_CTRL];
  wire ldo_word_t camd_trim = regs_q[LDO_R_CAMD_TRIM];
  wire ldo_word_t camio_ctrl = regs_q[LDO_R_CAMIO_CTRL];
  wire ldo_word_t camio_trim = regs_q[LDO_R_CAMIO_TRIM];

  // software enable per supply
  wire [8:0] sw_en = {
    general_supply_three_sw_enable,
    general_supply_two_sw_enable,
    general_supply_one_sw_enable,
    camio_ctrl[`LDO_BIT_CAM_EN],
    camd_ctrl[`LDO_BIT_CAM_EN],
    vib_ctrl[`LDO_BIT_SW_EN],
    sim_two_sw_enable,
    sim_one_sw_enable,
    focus_ctrl[`LDO_BIT_SW_EN]
  };

  // hardware takes over where the on-source bit is set
  wire [8:0] hw_src = {
    on_source[`LDO_BIT_GP3_ON_SRC],
    on_source[`LDO_BIT_GP2_ON_SRC],
    on_source[`LDO_BIT_GP1_ON_SRC],
    camio_trim[`LDO_BIT_CAM_ON_SRC],
    camd_trim[`LDO_BIT_CAM_ON_SRC],
    on_source[`LDO_BIT_VIB_ON_SRC],
    on_source[`LDO_BIT_SIM2_ON_SRC],
    on_source[`LDO_BIT_SIM1_ON_SRC],
    focus_trim[`LDO_BIT_FOCUS_ON_SRC]
  };

  // low-power selections for focus, vibrator, camera digital, camera io
  wire ldo_word_t lp_regs [4] = '{focus_ctrl, vib_ctrl, camd_ctrl, camio_ctrl};

  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_en
      assign enable_d[gi] = hw_src[gi] ? hw_on_request[gi] : sw_en[gi];
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_lp
      assign lowpower_d[gi] = lp_regs[gi][`LDO_BIT_LP_SRC] ?
        clock_request_input :
        lp_regs[gi][`LDO_BIT_LP_SET];
    end
  endgenerate

  // trim and voltage fields
  wire [3:0] focus_cal = focus_trim[`LDO_LSB_FOCUS_TRIM +: 4];
  wire [3:0] vib_cal = vib_trim[`LDO_LSB_VIB_TRIM +: 4];
  wire [3:0] sim1_cal = sim1_trim[`LDO_LSB_TRIM +: 4];
  wire [3:0] sim2_cal = sim2_trim[`LDO_LSB_TRIM +: 4];
  wire [3:0] camd_cal = camd_trim[`LDO_LSB_TRIM +: 4];
  wire [3:0] camio_cal = camio_trim[`LDO_LSB_TRIM +: 4];
  wire [2:0] focus_code = focus_trim[`LDO_LSB_VCODE +: 3];
  wire [2:0] vib_code = vib_trim[`LDO_LSB_VCODE +: 3];
  wire [1:0] camd_code = camd_trim[`LDO_LSB_VCODE +: 2];
  wire sim1_code = sim1_trim[`LDO_LSB_VCODE];
  wire sim2_code = sim2_trim[`LDO_LSB_VCODE];

  wire focus_at_1v3 = (focus_code == 3'h1);
  wire vib_at_1v3 = (vib_code == 3'h1);

  // camera io has no voltage code here; it reports zero nominal
  assign nominal_d[0] = vcode3_mv(focus_code);
  assign nominal_d[1] = sim1_code ? 12'd3000 : 12'd1800;
  assign nominal_d[2] = sim2_code ? 12'd3000 : 12'd1800;
  assign nominal_d[3] = vcode3_mv(vib_code);
  assign nominal_d[4] = camd_mv(camd_code);
  assign nominal_d[5] = 12'd0;

  assign trim_d[0] = trim_mv(focus_cal, focus_at_1v3);
  assign trim_d[1] = trim_mv(sim1_cal, 1'b0);
  assign trim_d[2] = trim_mv(sim2_cal, 1'b0);
  assign trim_d[3] = trim_mv(vib_cal, vib_at_1v3);
  assign trim_d[4] = trim_mv(camd_cal, 1'b0);
  assign trim_d[5] = trim_mv(camio_cal, 1'b0);

  // over-current flags land on odd bits 3 through 15
  ldo_word_t oc_word;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_oc
      if (gi >= `LDO_LSB_OC && gi % 2 == 1)
      begin : g_flag
        assign oc_word[gi] =
          overcurrent_flags[(gi - `LDO_LSB_OC) / 2];
      end
      else
      begin : g_zero
        assign oc_word[gi] = 1'b0;
      end
    end
  endgenerate

  // mode bit 7 shows the applied low-power state
  wire ldo_word_t mode_bit = ldo_word_t'(1) << `LDO_BIT_MODE;
  wire ldo_word_t en_bit = ldo_word_t'(1) << `LDO_BIT_EN_STATUS;

  wire ldo_word_t rd_focus_ctrl =
    focus_ctrl | (lowpower_q[0] ? mode_bit : 16'h0000);
  wire ldo_word_t rd_vib_ctrl =
    vib_ctrl | (lowpower_q[1] ? mode_bit : 16'h0000);
  wire ldo_word_t rd_camd_ctrl = camd_ctrl |
    (lowpower_q[2] ? mode_bit : 16'h0000) |
    (enable_q[LDO_S_CAMD] ? en_bit : 16'h0000);
  wire ldo_word_t rd_camio_ctrl = camio_ctrl |
    (lowpower_q[3] ? mode_bit : 16'h0000) |
    (enable_q[LDO_S_CAMIO] ? en_bit : 16'h0000);
  wire ldo_word_t rd_rf =
    rf_supply_lowpower ? mode_bit : 16'h0000;
  // bit 14 of these two carries its reset one as a fixed value
  wire ldo_word_t rd_mem = `LDO_RST_SUPPLY_STATUS |
    (memory_supply_on ? en_bit : 16'h0000) |
    (memory_supply_lowpower ? mode_bit : 16'h0000);
  wire ldo_word_t rd_io = `LDO_RST_SUPPLY_STATUS |
    (io_supply_on ? en_bit : 16'h0000) |
    (io_supply_lowpower ? mode_bit : 16'h0000);

  // read mux; reserved bits of trim registers return their reset ones
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_addr == `LDO_OFS_FOCUS_CTRL)
      rdata_d = rd_focus_ctrl;
    else if (reg_addr == `LDO_OFS_VIB_CTRL)
      rdata_d = rd_vib_ctrl;
    else if (reg_addr == `LDO_OFS_CAMD_CTRL)
      rdata_d = rd_camd_ctrl;
    else if (reg_addr == `LDO_OFS_CAMIO_CTRL)
      rdata_d = rd_camio_ctrl;
    else if (reg_addr == `LDO_OFS_OC_STATUS)
      rdata_d = oc_word;
    else if (reg_addr == `LDO_OFS_RF_STATUS)
      rdata_d = rd_rf;
    else if (reg_addr == `LDO_OFS_MEM_STATUS)
      rdata_d = rd_mem;
    else if (reg_addr == `LDO_OFS_IO_STATUS)
      rdata_d = rd_io;
    else if (rd_slot != 5'h1f)
      rdata_d = regs_q[rd_slot[3:0]] |
        (RW_RESET[rd_slot[3:0]] & ~RW_MASK[rd_slot[3:0]]);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid_q <= reg_rd_en;
      if (reg_rd_en)
        rdata_q <= rdata_d;
    end
  end

  // regulator controls are registered so the analog side sees clean levels
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_q <= 9'h000;
      lowpower_q <= 4'h0;
      nominal_q <= '0;
      trim_q <= '0;
    end
    else if (clk_en)
    begin
      enable_q <= enable_d;
      lowpower_q <= lowpower_d;
      nominal_q <= nominal_d;
      trim_q <= trim_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign supply_enable = enable_q;
  assign supply_lowpower = lowpower_q;
  assign supply_nominal_mv = nominal_q;
  assign supply_trim_mv = trim_q;

endmodule

// File: design/ldo_map.svh
// register offsets, field positions and reset values of the regulator bank
`ifndef LDO_MAP_SVH
`define LDO_MAP_SVH

`define LDO_OFS_FOCUS_CTRL 16'h0536
`define LDO_OFS_FOCUS_TRIM 16'h0538
`define LDO_OFS_SIM1_TRIM 16'h053c
`define LDO_OFS_SIM2_TRIM 16'h053e
`define LDO_OFS_VIB_CTRL 16'h0542
`define LDO_OFS_VIB_TRIM 16'h0544
`define LDO_OFS_OC_STATUS 16'h0548
`define LDO_OFS_ON_SOURCE 16'h054c
`define LDO_OFS_RF_STATUS 16'h054e
`define LDO_OFS_MEM_STATUS 16'h0552
`define LDO_OFS_IO_STATUS 16'h0556
`define LDO_OFS_CAMD_CTRL 16'h055a
`define LDO_OFS_CAMD_TRIM 16'h055c
`define LDO_OFS_CAMIO_CTRL 16'h055e
`define LDO_OFS_CAMIO_TRIM 16'h0560

`define LDO_RST_FOCUS_TRIM 16'h0081
`define LDO_RST_SIM_TRIM 16'h0001
`define LDO_RST_VIB_TRIM 16'h0101
`define LDO_RST_CAM_TRIM 16'h0001
`define LDO_RST_SUPPLY_STATUS 16'h4000
`define LDO_RST_ZERO 16'h0000

`define LDO_MASK_LP_CTRL 16'h8003
`define LDO_MASK_CAM_CTRL 16'h4003
`define LDO_MASK_FOCUS_TRIM 16'h78e8
`define LDO_MASK_SIM_TRIM 16'h0f20
`define LDO_MASK_VIB_TRIM 16'h3ce0
`define LDO_MASK_ON_SOURCE 16'he380
`define LDO_MASK_CAMD_TRIM 16'h0f62
`define LDO_MASK_CAMIO_TRIM 16'h0f02

`define LDO_BIT_SW_EN 15
`define LDO_BIT_EN_STATUS 15
`define LDO_BIT_CAM_EN 14
`define LDO_BIT_MODE 7
`define LDO_BIT_LP_SET 1
`define LDO_BIT_LP_SRC 0
`define LDO_BIT_FOCUS_ON_SRC 3
`define LDO_BIT_CAM_ON_SRC 1
`define LDO_BIT_GP1_ON_SRC 15
`define LDO_BIT_GP2_ON_SRC 14
`define LDO_BIT_GP3_ON_SRC 13
`define LDO_BIT_SIM1_ON_SRC 9
`define LDO_BIT_SIM2_ON_SRC 8
`define LDO_BIT_VIB_ON_SRC 7
`define LDO_LSB_FOCUS_TRIM 11
`define LDO_LSB_VIB_TRIM 10
`define LDO_LSB_TRIM 8
`define LDO_LSB_VCODE 5
`define LDO_LSB_OC 3

`endif

// File: design/ldo_pkg.sv
// types shared by the regulator control bank
package ldo_pkg;
  typedef logic [15:0] ldo_word_t;
  typedef logic [11:0] ldo_mv_t;
  typedef logic signed [8:0] ldo_trim_t;
  // storage slots of the writable registers
  typedef enum logic [3:0] {
    LDO_R_FOCUS_CTRL = 4'h0,
    LDO_R_FOCUS_TRIM = 4'h1,
    LDO_R_SIM1_TRIM = 4'h2,
    LDO_R_SIM2_TRIM = 4'h3,
    LDO_R_VIB_CTRL = 4'h4,
    LDO_R_VIB_TRIM = 4'h5,
    LDO_R_ON_SOURCE = 4'h6,
    LDO_R_CAMD_CTRL = 4'h7,
    LDO_R_CAMD_TRIM = 4'h8,
    LDO_R_CAMIO_CTRL = 4'h9,
    LDO_R_CAMIO_TRIM = 4'ha
  } ldo_rw_idx_t;
  // supply order on the enable and voltage output vectors
  typedef enum logic [3:0] {
    LDO_S_FOCUS = 4'h0,
    LDO_S_SIM1 = 4'h1,
    LDO_S_SIM2 = 4'h2,
    LDO_S_VIB = 4'h3,
    LDO_S_CAMD = 4'h4,
    LDO_S_CAMIO = 4'h5,
    LDO_S_GP1 = 4'h6,
    LDO_S_GP2 = 4'h7,
    LDO_S_GP3 = 4'h8
  } ldo_supply_t;
endpackage

// File: tb/ldo_ctrl_bank_props.sv
// concurrent checks on the regulator bank ports
module ldo_ctrl_bank_props
  import ldo_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire ldo_word_t reg_wdata,
  input wire logic reg_rd_en,
  input wire ldo_word_t reg_rdata,
  input wire logic reg_rd_valid,
  // requests and status
  input wire logic [8:0] hw_on_request,
  input wire logic sim_one_sw_enable,
  input wire logic general_supply_one_sw_enable,
  input wire logic [6:0] overcurrent_flags,
  // regulator controls
  input wire logic [8:0] supply_enable,
  input wire ldo_mv_t [5:0] supply_nominal_mv
);
  logic up_q;
  ldo_word_t on_q, camc_q, camt_q, oc_word;
  wire wr = reg_wr_en && clk_en;
  wire rd = reg_rd_en && clk_en;
  wire mapped = reg_addr inside {16'h0536, 16'h0538, 16'h053c, 16'h053e,
    16'h0542, 16'h0544, 16'h0548, 16'h054c, 16'h054e, 16'h0552, 16'h0556,
    16'h055a, 16'h055c, 16'h055e, 16'h0560};
  // mV of the camera digital code held in the shadow copy
  wire ldo_mv_t camd_mv = camt_q[6] ? (camt_q[5] ? 12'h708 : 12'h5dc)
    : (camt_q[5] ? 12'h546 : 12'h4b0);
  always_comb
  begin
    oc_word = 16'h0000;
    for (int k = 0; k < 7; k++)
      oc_word[3 + 2 * k] = overcurrent_flags[k];
  end
  // shadows of the writable fields the checks depend on
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      up_q <= 1'b0;
      {on_q, camc_q, camt_q} <= '0;
    end
    else if (clk_en)
    begin
      up_q <= 1'b1;
      if (wr && reg_addr == 16'h054c)
        on_q <= reg_wdata;
      if (wr && reg_addr == 16'h055a)
        camc_q <= reg_wdata;
      if (wr && reg_addr == 16'h055c)
        camt_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rd_valid;
    up_q && $past(clk_en) |-> reg_rd_valid == $past(reg_rd_en);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid");
  property p_rd_hold;
    !reg_rd_valid |-> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped;
    rd && !mapped |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_oc;
    rd && reg_addr == 16'h0548 |=> reg_rdata == $past(oc_word);
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent word");
  property p_gp1;
    up_q && $past(clk_en) |-> supply_enable[6] == $past(on_q[15] ?
      hw_on_request[6] : general_supply_one_sw_enable);
  endproperty
  a_gp1: assert property (p_gp1) else $error("gp1 enable");
  property p_sim1;
    up_q && $past(clk_en) |-> supply_enable[1] == $past(on_q[9] ?
      hw_on_request[1] : sim_one_sw_enable);
  endproperty
  a_sim1: assert property (p_sim1) else $error("sim1 enable");
  property p_camd_en;
    up_q && $past(clk_en) |-> supply_enable[4] == $past(camt_q[1] ?
      hw_on_request[4] : camc_q[14]);
  endproperty
  a_camd_en: assert property (p_camd_en) else $error("camd enable");
  property p_camd_mv;
    up_q && $past(clk_en) |-> supply_nominal_mv[4] == $past(camd_mv);
  endproperty
  a_camd_mv: assert property (p_camd_mv) else $error("camd mv");
  c_oc: cover property (rd && reg_addr == 16'h0548);
  c_src: cover property (wr && reg_addr == 16'h054c);
  c_unm: cover property (rd && !mapped);
endmodule

bind ldo_ctrl_bank ldo_ctrl_bank_props u_ldo_ctrl_bank_props (.ref_clk,
  .resetn, .clk_en, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
  .reg_rdata, .reg_rd_valid, .hw_on_request, .sim_one_sw_enable,
  .general_supply_one_sw_enable, .overcurrent_flags, .supply_enable,
  .supply_nominal_mv);

// File: tb/test_ldo_control_register_bank.sv
// self-checking bench for the regulator control register bank
module test_ldo_control_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import ldo_pkg::*;
  logic ref_clk, resetn, clk_en, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic clock_request_input, lp_exp;
  logic [15:0] reg_addr, oc_exp;
  ldo_word_t reg_wdata, reg_rdata;
  logic [8:0] hw_on_request, supply_enable;
  logic [4:0] sw_en;
  logic [4:0] st_in;
  logic [6:0] overcurrent_flags;
  logic [3:0] supply_lowpower;
  ldo_mv_t [5:0] supply_nominal_mv;
  ldo_trim_t [5:0] supply_trim_mv;
  int fail_count = 0;
  int cmp_count = 0;
  // nominal mV per voltage code
  ldo_mv_t vtab[8] = '{12'h4b0, 12'h514, 12'h5dc, 12'h708, 12'h7d0,
    12'haf0, 12'hbb8, 12'hce4};
  ldo_mv_t ctab[4] = '{12'h4b0, 12'h546, 12'h5dc, 12'h708};
  logic [15:0] lp_reg[4] = '{16'h0536, 16'h0542, 16'h055a, 16'h055e};
  // address, write data, readback; first 15 rows only read reset values
  logic [47:0] rows[28] = '{
    {16'h0536, 16'h0, 16'h0}, {16'h0538, 16'h0, 16'h0081},
    {16'h053c, 16'h0, 16'h0001}, {16'h053e, 16'h0, 16'h0001},
    {16'h0542, 16'h0, 16'h0}, {16'h0544, 16'h0, 16'h0101},
    {16'h0548, 16'h0, 16'h0}, {16'h054c, 16'h0, 16'h0},
    {16'h054e, 16'h0, 16'h0}, {16'h0552, 16'h0, 16'h4000},
    {16'h0556, 16'h0, 16'h4000}, {16'h055a, 16'h0, 16'h0},
    {16'h055c, 16'h0, 16'h0001}, {16'h055e, 16'h0, 16'h0},
    {16'h0560, 16'h0, 16'h0001}, {16'h0538, 16'hffff, 16'h78e9},
    {16'h053c, 16'hffff, 16'h0f21}, {16'h053e, 16'h0, 16'h0001},
    {16'h0544, 16'hffff, 16'h3de1}, {16'h054c, 16'hffff, 16'he380},
    {16'h0548, 16'hffff, 16'h0}, {16'h0552, 16'hffff, 16'h4000},
    {16'h055a, 16'hffff, 16'hc003}, {16'h055e, 16'h4002, 16'hc082},
    {16'h0560, 16'h0f03, 16'h0f03}, {16'h055c, 16'hffff, 16'h0f63},
    {16'h0570, 16'hffff, 16'h0}, {16'h0536, 16'hffff, 16'h8003}};

  ldo_ctrl_bank u_ldo_ctrl_bank (.ref_clk, .resetn, .clk_en, .reg_addr,
    .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid,
    .clock_request_input, .hw_on_request, .sim_one_sw_enable(sw_en[0]),
    .sim_two_sw_enable(sw_en[1]), .general_supply_one_sw_enable(sw_en[2]),
    .general_supply_two_sw_enable(sw_en[3]),
    .general_supply_three_sw_enable(sw_en[4]), .overcurrent_flags,
    .rf_supply_lowpower(st_in[0]), .memory_supply_on(st_in[1]),
    .memory_supply_lowpower(st_in[2]), .io_supply_on(st_in[3]),
    .io_supply_lowpower(st_in[4]), .supply_enable, .supply_lowpower,
    .supply_nominal_mv, .supply_trim_mv);

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // outputs follow a write one edge after the strobe edge; the task waits two
  task automatic wr(logic [15:0] a, logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    step();
    reg_wr_en = 1'b0;
    step(2);
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    step();
    reg_rd_en = 1'b0;
    chk("read valid", 16'h0001, 16'(reg_rd_valid));
    chk($sformatf("reg %h", a), e, reg_rdata);
    // one idle edge so a following strobe is never re-raised in this step
    step();
  endtask
  function automatic int trim_mv(int c, int v);
    if (c >= 8)
      return 160 - 20 * (c - 8);
    if (v == 1 && c >= 4)
      return -20 * (c - 4);
    return -20 * c;
  endfunction
  task automatic chk_sup(int s, ldo_mv_t nom, int trim);
    chk($sformatf("nominal %0d", s), 16'(nom), 16'(supply_nominal_mv[s]));
    chk($sformatf("trim %0d", s), 16'(trim),
      16'($signed(supply_trim_mv[s])));
  endtask
  task automatic set_src(logic [15:0] on, logic [15:0] f, logic [15:0] c);
    wr(16'h054c, on);
    wr(16'h0538, f);
    wr(16'h055c, c);
    wr(16'h0560, c);
  endtask
  task automatic run_rows(int n);
    for (int i = 0; i < n; i++)
    begin
      if (i >= 15)
        wr(rows[i][47:32], rows[i][31:16]);
      rd(rows[i][47:32], rows[i][15:0]);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
  initial
  begin
    resetn = 1'b0;
    clk_en = 1'b1;
    {reg_wr_en, reg_rd_en, clock_request_input} = '0;
    {reg_addr, reg_wdata, hw_on_request, sw_en, overcurrent_flags} = '0;
    st_in = 5'h00;
    repeat (8) @(posedge ref_clk);
    #1 resetn = 1'b1;
    run_rows(28);
    for (int v = 0; v < 8; v++)
      for (int c = 0; c < 16; c++)
      begin
        wr(16'h0538, 16'((c << 11) | (v << 5)));
        wr(16'h0544, 16'((c << 10) | (v << 5)));
        chk_sup(0, vtab[v], trim_mv(c, v));
        chk_sup(3, vtab[v], trim_mv(c, v));
      end
    for (int k = 0; k < 4; k++)
    begin
      wr(16'h053c, 16'((k << 5) | ((k + 8) << 8)));
      wr(16'h053e, 16'((k << 5) | ((k + 8) << 8)));
      wr(16'h055c, 16'((k << 5) | (k << 8)));
      wr(16'h0560, 16'((k + 8) << 8));
      chk_sup(1, k[0] ? 12'hbb8 : 12'h708, 160 - 20 * k);
      chk_sup(2, k[0] ? 12'hbb8 : 12'h708, 160 - 20 * k);
      chk_sup(4, ctab[k], -20 * k);
      chk_sup(5, 12'h000, 160 - 20 * k);
    end
    for (int m = 0; m < 32; m++)
    begin
      clock_request_input = m[2];
      lp_exp = m[0] ? m[2] : m[1];
      wr(lp_reg[m[4:3]], 16'(m[1:0]));
      chk("lowpower", 16'(lp_exp),
        16'(supply_lowpower[m[4:3]]));
    end
    clock_request_input = 1'b0;
    hw_on_request = 9'h1ff;
    set_src(16'h0, 16'h0, 16'h0);
    for (int j = 0; j < 4; j++)
      wr(lp_reg[j], j < 2 ? 16'h8000 : 16'h4000);
    chk("enable", 16'h0039, 16'(supply_enable));
    rd(16'h055a, 16'hc000);
    sw_en = 5'h1f;
    step(2);
    chk("enable", 16'h01ff, 16'(supply_enable));
    hw_on_request = 9'h0;
    set_src(16'hffff, 16'h0008, 16'h0002);
    chk("enable", 16'h0000, 16'(supply_enable));
    hw_on_request = 9'h1ff;
    step(2);
    chk("enable", 16'h01ff, 16'(supply_enable));
    for (int j = 0; j < 2; j++)
    begin
      overcurrent_flags = j ? 7'h2a : 7'h55;
      oc_exp = 16'h0;
      for (int k = 0; k < 7; k++)
        oc_exp[3 + 2 * k] = overcurrent_flags[k];
      rd(16'h0548, oc_exp);
    end
    // flags cleared so the reset rows later read a zero status word
    overcurrent_flags = 7'h00;
    st_in = 5'h1f;
    rd(16'h054e, 16'h0080);
    rd(16'h0552, 16'hc080);
    rd(16'h0556, 16'hc080);
    st_in = 5'h00;
    // a frozen bank must take neither strobe
    step();
    clk_en = 1'b0;
    reg_addr = 16'h0544;
    reg_wdata = 16'h0;
    {reg_wr_en, reg_rd_en} = 2'b11;
    step(3);
    chk("frozen valid", 16'h0, 16'(reg_rd_valid));
    {reg_wr_en, reg_rd_en} = 2'b00;
    clk_en = 1'b1;
    step();
    rd(16'h0544, 16'h3de1);
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    run_rows(15);
    end_sim();
  end
endmodule
